/* File: cpfs_map.svh */
// register offsets, field positions, reset values for the pin function select
// Overview of operation
// - power field 00 makes the asserted power pin force full power-down; reset 00.
// - power field 01 makes the asserted power pin force standby instead.
// - power field 10 (and 11) ignores the power pin entirely.
// - an honoured asserted power pin clears chan_power_en; the channel power mode bits still pass through.
// - B role field 000 fast-detect B, 001 frame clock, 110 secondary role.
// - A role field uses the same codes for fast-detect A.
// - role 111 disables the pin as weakly pulled-down input; fields reset 111.
// - B secondary role applies only while B role field is 110.
// - A secondary role applies only while A role field is 110.
// - B secondary 0000 oscillator select input, 0001 transfer input; reset 0000.
// - A secondary 0000 oscillator select input, 0001 transfer input.
// - secondary 1000 drives the leader next-trigger output on the pin.
// - transfer request loads shadow into active; flag clears after copy done.
`ifndef CPFS_MAP_SVH
`define CPFS_MAP_SVH
`define CPFS_ADDR_XFER 16'h000F
`define CPFS_ADDR_PRI 16'h0040
`define CPFS_ADDR_SEC 16'h0041
`define CPFS_PRI_RESET 8'h3F
`define CPFS_SEC_RESET 8'h00
`define CPFS_PWR_MSB 7
`define CPFS_PWR_LSB 6
`define CPFS_ROLE_B_MSB 5
`define CPFS_ROLE_B_LSB 3
`define CPFS_ROLE_A_MSB 2
`define CPFS_ROLE_A_LSB 0
`define CPFS_SEC_B_MSB 7
`define CPFS_SEC_B_LSB 4
`define CPFS_SEC_A_MSB 3
`define CPFS_SEC_A_LSB 0
`define CPFS_XFER_BIT 0
`endif

/* File: cpfs_pkg.sv */
// types of the pin function select
package cpfs_pkg;
	typedef enum logic [1:0] {
		CPFS_PWR_FULL = 2'b00,
		CPFS_PWR_STBY = 2'b01,
		CPFS_PWR_OFF = 2'b10
	} cpfs_pwr_e;
	typedef enum logic [2:0] {
		CPFS_ROLE_FD = 3'b000,
		CPFS_ROLE_LMFC = 3'b001,
		CPFS_ROLE_SEC = 3'b110,
		CPFS_ROLE_OFF = 3'b111
	} cpfs_role_e;
	typedef enum logic [3:0] {
		CPFS_SEC_NCO = 4'b0000,
		CPFS_SEC_XFER = 4'b0001,
		CPFS_SEC_LEAD = 4'b1000,
		CPFS_SEC_FOLL = 4'b1001
	} cpfs_sec_e;
endpackage : cpfs_pkg

/* File: cpfs_pin_cell.sv */
// role decode and output flops of one multipurpose pin
`timescale 1ns/1ps
module cpfs_pin_cell
	import cpfs_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// configuration
	input wire logic [2:0] role,
	input wire logic [3:0] sec_role,
	// sources and synchronised pin level
	input wire logic pin_sync,
	input wire logic fd_flag,
	input wire logic lmfc,
	input wire logic leader_trig,
	// pin drive
	output logic pin_out,
	output logic pin_oe,
	output logic pull_down,
	// decoded input roles
	output logic sel_lvl,
	output logic xfer_lvl,
	output logic trig_lvl
);
	logic pin_out_ff;
	logic pin_oe_ff;
	logic pull_down_ff;
	logic nxt_pin_out;
	logic nxt_pin_oe;
	logic nxt_pull_down;

	always_comb
	begin
		nxt_pin_out = 1'b0;
		nxt_pin_oe = 1'b0;
		nxt_pull_down = 1'b1;
		sel_lvl = 1'b0;
		xfer_lvl = 1'b0;
		trig_lvl = 1'b0;
		unique case (role)
			CPFS_ROLE_FD:
			begin
				nxt_pin_oe = 1'b1;
				nxt_pin_out = fd_flag;
				nxt_pull_down = 1'b0;
			end
			CPFS_ROLE_LMFC:
			begin
				nxt_pin_oe = 1'b1;
				nxt_pin_out = lmfc;
				nxt_pull_down = 1'b0;
			end
			CPFS_ROLE_SEC:
			begin
				unique case (sec_role)
					CPFS_SEC_NCO:
					begin
						nxt_pull_down = 1'b0;
						sel_lvl = pin_sync;
					end
					CPFS_SEC_XFER:
					begin
						nxt_pull_down = 1'b0;
						xfer_lvl = pin_sync;
					end
					CPFS_SEC_LEAD:
					begin
						nxt_pin_oe = 1'b1;
						nxt_pin_out = leader_trig;
						nxt_pull_down = 1'b0;
					end
					CPFS_SEC_FOLL:
					begin
						nxt_pull_down = 1'b0;
						trig_lvl = pin_sync;
					end
					default:
					begin
						nxt_pull_down = 1'b1;
					end
				endcase
			end
			default:
			begin
				nxt_pull_down = 1'b1;
			end
		endcase
	end

	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
		begin
			pin_out_ff <= 1'b0;
			pin_oe_ff <= 1'b0;
			pull_down_ff <= 1'b1;
		end
		else
		begin
			pin_out_ff <= nxt_pin_out;
			pin_oe_ff <= nxt_pin_oe;
			pull_down_ff <= nxt_pull_down;
		end
	end

	assign pin_out = pin_out_ff;
	assign pin_oe = pin_oe_ff;
	assign pull_down = pull_down_ff;
endmodule : cpfs_pin_cell

/* File: cpfs_pin_select.sv */
// pin control registers, power pin handling and multipurpose pin muxing
`timescale 1ns/1ps
`include "cpfs_map.svh"
module cpfs_pin_select
	import cpfs_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// register access from the serial control port
	input wire logic [15:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// power
	input wire logic power_down_standby_pin,
	input wire logic [1:0] chan_power_mode,
	output logic chip_power_down,
	output logic chip_standby,
	output logic chan_power_en,
	output logic [1:0] chan_power_mode_eff,
	// signal sources
	input wire logic overrange_flag_a,
	input wire logic overrange_flag_b,
	input wire logic lmfc,
	input wire logic leader_trigger_out,
	// multipurpose pin a
	input wire logic multipurpose_pin_a_in,
	output logic multipurpose_pin_a_out,
	output logic multipurpose_pin_a_oe,
	output logic multipurpose_pin_a_pd,
	// multipurpose pin b
	input wire logic multipurpose_pin_b_in,
	output logic multipurpose_pin_b_out,
	output logic multipurpose_pin_b_oe,
	output logic multipurpose_pin_b_pd,
	// decoded pin inputs
	output logic [1:0] nco_chan_sel,
	output logic follower_trigger_in,
	// shadow to active transfer
	output logic xfer_load,
	input wire logic xfer_done
);
	logic [7:0] pri_ff;
	logic [7:0] sec_ff;
	logic xfer_req_ff;
	logic nxt_xfer_req;
	logic [7:0] rdata_ff;
	logic [1:0] pwr_sync_ff;
	logic [1:0] pin_s1_ff;
	logic [1:0] pin_s2_ff;
	logic chip_power_down_ff;
	logic chip_standby_ff;
	logic chan_power_en_ff;
	logic [1:0] chan_power_mode_ff;
	logic [1:0] nco_sel_ff;
	logic xfer_prev_ff;
	logic trig_prev_ff;
	logic follower_trig_ff;
	logic [1:0] pwr_mode;
	logic pwr_pin;
	logic pwr_honour;
	logic xfer_wr;
	logic xfer_rise;
	logic [1:0] sel_lvl;
	logic [1:0] xfer_lvl;
	logic [1:0] trig_lvl;
	logic [1:0] pin_out;
	logic [1:0] pin_oe;
	logic [1:0] pin_pd;
	logic [2:0] role [1:0];
	logic [3:0] sec_role [1:0];
	logic [1:0] fd_flag;
	logic [1:0] pin_in;

	function automatic logic hit(input logic [15:0] a, input logic [15:0] b);
		hit = (a == b);
	endfunction : hit

	// register file
	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
		begin
			pri_ff <= `CPFS_PRI_RESET;
			sec_ff <= `CPFS_SEC_RESET;
		end
		else if (reg_wr)
		begin
			if (hit(reg_addr, `CPFS_ADDR_PRI))
				pri_ff <= reg_wdata;
			if (hit(reg_addr, `CPFS_ADDR_SEC))
				sec_ff <= reg_wdata;
		end
	end

	// read data
	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
			rdata_ff <= 8'h00;
		else if (reg_rd)
		begin
			if (hit(reg_addr, `CPFS_ADDR_PRI))
				rdata_ff <= pri_ff;
			else if (hit(reg_addr, `CPFS_ADDR_SEC))
				rdata_ff <= sec_ff;
			else if (hit(reg_addr, `CPFS_ADDR_XFER))
				rdata_ff <= {7'h00, xfer_req_ff};
			else
				rdata_ff <= 8'h00;
		end
	end

	// transfer request, set wins over clear
	assign xfer_wr = reg_wr && hit(reg_addr, `CPFS_ADDR_XFER) &&
		reg_wdata[`CPFS_XFER_BIT];
	assign xfer_rise = (|xfer_lvl) && !xfer_prev_ff;
	assign nxt_xfer_req = xfer_wr || xfer_rise || (xfer_req_ff && !xfer_done);

	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
			xfer_req_ff <= 1'b0;
		else
			xfer_req_ff <= nxt_xfer_req;
	end

	// synchronisers
	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
		begin
			pwr_sync_ff <= 2'h0;
			pin_s1_ff <= 2'h0;
			pin_s2_ff <= 2'h0;
		end
		else
		begin
			pwr_sync_ff <= {pwr_sync_ff[0], power_down_standby_pin};
			pin_s1_ff <= {multipurpose_pin_b_in, multipurpose_pin_a_in};
			pin_s2_ff <= pin_s1_ff;
		end
	end

	// power pin handling
	assign pwr_mode = pri_ff[`CPFS_PWR_MSB:`CPFS_PWR_LSB];
	assign pwr_pin = pwr_sync_ff[1];
	assign pwr_honour = pwr_pin && (pwr_mode == CPFS_PWR_FULL ||
		pwr_mode == CPFS_PWR_STBY);

	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
		begin
			chip_power_down_ff <= 1'b0;
			chip_standby_ff <= 1'b0;
			chan_power_en_ff <= 1'b1;
			chan_power_mode_ff <= 2'h0;
		end
		else
		begin
			chip_power_down_ff <= pwr_honour && (pwr_mode == CPFS_PWR_FULL);
			chip_standby_ff <= pwr_honour && (pwr_mode == CPFS_PWR_STBY);
			chan_power_en_ff <= !pwr_honour;
			chan_power_mode_ff <= chan_power_mode;
		end
	end

	// per-pin role decode
	assign role[0] = pri_ff[`CPFS_ROLE_A_MSB:`CPFS_ROLE_A_LSB];
	assign role[1] = pri_ff[`CPFS_ROLE_B_MSB:`CPFS_ROLE_B_LSB];
	assign sec_role[0] = sec_ff[`CPFS_SEC_A_MSB:`CPFS_SEC_A_LSB];
	assign sec_role[1] = sec_ff[`CPFS_SEC_B_MSB:`CPFS_SEC_B_LSB];
	assign fd_flag = {overrange_flag_b, overrange_flag_a};
	assign pin_in = pin_s2_ff;

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++)
		begin : g_pin
			cpfs_pin_cell u_cell (
				.sys_clk(sys_clk),
				.reset(reset),
				.role(role[gi]),
				.sec_role(sec_role[gi]),
				.pin_sync(pin_in[gi]),
				.fd_flag(fd_flag[gi]),
				.lmfc(lmfc),
				.leader_trig(leader_trigger_out),
				.pin_out(pin_out[gi]),
				.pin_oe(pin_oe[gi]),
				.pull_down(pin_pd[gi]),
				.sel_lvl(sel_lvl[gi]),
				.xfer_lvl(xfer_lvl[gi]),
				.trig_lvl(trig_lvl[gi])
			);
		end
	endgenerate

	// decoded inputs and edges
	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
		begin
			nco_sel_ff <= 2'h0;
			xfer_prev_ff <= 1'b0;
			trig_prev_ff <= 1'b0;
			follower_trig_ff <= 1'b0;
		end
		else
		begin
			nco_sel_ff <= sel_lvl;
			xfer_prev_ff <= |xfer_lvl;
			trig_prev_ff <= |trig_lvl;
			follower_trig_ff <= (|trig_lvl) && !trig_prev_ff;
		end
	end

	assign reg_rdata = rdata_ff;
	assign chip_power_down = chip_power_down_ff;
	assign chip_standby = chip_standby_ff;
	assign chan_power_en = chan_power_en_ff;
	assign chan_power_mode_eff = chan_power_mode_ff;
	assign multipurpose_pin_a_out = pin_out[0];
	assign multipurpose_pin_a_oe = pin_oe[0];
	assign multipurpose_pin_a_pd = pin_pd[0];
	assign multipurpose_pin_b_out = pin_out[1];
	assign multipurpose_pin_b_oe = pin_oe[1];
	assign multipurpose_pin_b_pd = pin_pd[1];
	assign nco_chan_sel = nco_sel_ff;
	assign follower_trigger_in = follower_trig_ff;
	assign xfer_load = xfer_req_ff;

	// checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	property p_full_pd;
		(pwr_pin && pwr_mode == 2'b00) |=> chip_power_down && !chip_standby;
	endproperty
	a_full_pd: assert property (p_full_pd) else $error("no full power-down");

	property p_standby;
		(pwr_pin && pwr_mode == 2'b01) |=> chip_standby && !chip_power_down;
	endproperty
	a_standby: assert property (p_standby) else $error("no standby");

	property p_ignored;
		pwr_mode[1] |=> !chip_power_down && !chip_standby && chan_power_en;
	endproperty
	a_ignored: assert property (p_ignored) else $error("pin not ignored");

	property p_override;
		(pwr_pin && !pwr_mode[1]) |=> !chan_power_en;
	endproperty
	a_override: assert property (p_override) else $error("no override");

	property p_fd_b;
		(role[1] == 3'b000) |=> multipurpose_pin_b_oe &&
			multipurpose_pin_b_out == $past(overrange_flag_b);
	endproperty
	a_fd_b: assert property (p_fd_b) else $error("fd b not driven");

	property p_lmfc_a;
		(role[0] == 3'b001) |=> multipurpose_pin_a_oe &&
			multipurpose_pin_a_out == $past(lmfc);
	endproperty
	a_lmfc_a: assert property (p_lmfc_a) else $error("lmfc a not driven");

	property p_disabled;
		(role[1] == 3'b111) |=> !multipurpose_pin_b_oe && multipurpose_pin_b_pd;
	endproperty
	a_disabled: assert property (p_disabled) else $error("pin b not off");

	property p_sec_gate_b;
		(role[1] == 3'b111 && sec_role[1] == 4'b0000) |=> nco_chan_sel[1] == 1'b0;
	endproperty
	a_sec_gate_b: assert property (p_sec_gate_b) else $error("sec b leak");

	property p_nco_a;
		(role[0] == 3'b110 && sec_role[0] == 4'b0000) |=>
			nco_chan_sel[0] == $past(pin_s2_ff[0]);
	endproperty
	a_nco_a: assert property (p_nco_a) else $error("nco sel a wrong");

	property p_leader_a;
		(role[0] == 3'b110 && sec_role[0] == 4'b1000) |=>
			multipurpose_pin_a_oe && multipurpose_pin_a_out == $past(leader_trigger_out);
	endproperty
	a_leader_a: assert property (p_leader_a) else $error("leader out wrong");

	sequence s_xfer_rise;
		!(|xfer_lvl) ##1 (|xfer_lvl);
	endsequence
	property p_xfer_pin;
		s_xfer_rise |=> xfer_load;
	endproperty
	a_xfer_pin: assert property (p_xfer_pin) else $error("pin transfer lost");

	property p_xfer_hold;
		(xfer_load && !xfer_done) |=> xfer_load;
	endproperty
	a_xfer_hold: assert property (p_xfer_hold) else $error("transfer dropped");

	property p_unlisted;
		(role[0] == 3'b010) |=> !multipurpose_pin_a_oe && multipurpose_pin_a_pd;
	endproperty
	a_unlisted: assert property (p_unlisted) else $error("unlisted drives");
endmodule : cpfs_pin_select

/* File: cpfs_host_model.sv */
// far-side logic that drives and samples the two multipurpose pins
`timescale 1ns/1ps
module cpfs_host_model
(
	// clock
	input wire logic sys_clk,
	// design drive of pin a
	input wire logic a_out,
	input wire logic a_oe,
	input wire logic a_pd,
	// design drive of pin b
	input wire logic b_out,
	input wire logic b_oe,
	input wire logic b_pd,
	// far-side drive {b,a}
	input wire logic [1:0] drv_en,
	input wire logic [1:0] drv_val,
	// resolved pin levels
	output logic pin_a,
	output logic pin_b
);
	logic [1:0] tog = 2'h0;
	// floating pin with no pull wanders each cycle
	always @(posedge sys_clk)
		tog <= ~tog;
	// host drives select, transfer and trigger levels
	assign pin_a = a_oe ? a_out : drv_en[0] ? drv_val[0] :
		a_pd ? 1'b0 : tog[0];
	assign pin_b = b_oe ? b_out : drv_en[1] ? drv_val[1] :
		b_pd ? 1'b0 : tog[1];
endmodule : cpfs_host_model

/* File: cpfs_pin_select_tb.sv */
// self-checking bench of the pin function select
`timescale 1ns/1ps
`include "cpfs_map.svh"
module cpfs_pin_select_tb;
	logic sys_clk = 1'b0;
	logic reset = 1'b1;
	logic [15:0] reg_addr = 16'h0000;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic pwr_pin = 1'b0;
	logic [1:0] chan_mode = 2'h2;
	logic fd_a = 1'b0;
	logic fd_b = 1'b0;
	logic lmfc = 1'b0;
	logic lead = 1'b0;
	logic xdone = 1'b0;
	logic [1:0] drv_en = 2'h0;
	logic [1:0] drv_val = 2'h0;
	logic [7:0] reg_rdata;
	logic pin_a, pin_b, a_out, a_oe, a_pd, b_out, b_oe, b_pd;
	logic pdn, stby, cen, ftrig, xload;
	logic [1:0] ceff, nsel;
	int n_errors = 0;
	int compares = 0;
	int i, k;

	always #50 sys_clk = ~sys_clk;

	cpfs_pin_select cpfs_pin_select_i (.sys_clk(sys_clk), .reset(reset),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.power_down_standby_pin(pwr_pin), .chan_power_mode(chan_mode),
		.chip_power_down(pdn), .chip_standby(stby), .chan_power_en(cen),
		.chan_power_mode_eff(ceff), .overrange_flag_a(fd_a),
		.overrange_flag_b(fd_b), .lmfc(lmfc), .leader_trigger_out(lead),
		.multipurpose_pin_a_in(pin_a), .multipurpose_pin_a_out(a_out),
		.multipurpose_pin_a_oe(a_oe), .multipurpose_pin_a_pd(a_pd),
		.multipurpose_pin_b_in(pin_b), .multipurpose_pin_b_out(b_out),
		.multipurpose_pin_b_oe(b_oe), .multipurpose_pin_b_pd(b_pd),
		.nco_chan_sel(nsel), .follower_trigger_in(ftrig),
		.xfer_load(xload), .xfer_done(xdone));

	cpfs_host_model cpfs_host_model_i (.sys_clk(sys_clk), .a_out(a_out),
		.a_oe(a_oe), .a_pd(a_pd), .b_out(b_out), .b_oe(b_oe), .b_pd(b_pd),
		.drv_en(drv_en), .drv_val(drv_val), .pin_a(pin_a), .pin_b(pin_b));

	task cmp(input logic [7:0] got, input logic [7:0] exp, input string w);
		compares++;
		if (got !== exp)
		begin
			n_errors++;
			$display("wrong value at %0t: %s got %h want %h", $time, w, got, exp);
		end
	endtask : cmp

	task pin_chk(input logic [2:0] ea, input logic [2:0] eb);
		cmp({5'h00, a_out, a_oe, a_pd}, {5'h00, ea}, "pin a");
		cmp({5'h00, b_out, b_oe, b_pd}, {5'h00, eb}, "pin b");
	endtask : pin_chk

	task wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask : wr

	task rd(input logic [15:0] a, input logic [7:0] e);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 cmp(reg_rdata, e, "read");
	endtask : rd

	task settle;
		repeat (5) @(posedge sys_clk);
		#1;
	endtask : settle

	task done_test(input string name);
		$display("test %s done: %0d compares %0d errors", name, compares,
			n_errors);
	endtask : done_test

	task complete_run;
		$display("counts: %0d compares %0d errors", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : complete_run

	initial
	begin
		repeat (4) @(posedge sys_clk);
		reset <= 1'b0;
		rd(`CPFS_ADDR_PRI, 8'h3f);
		rd(`CPFS_ADDR_SEC, 8'h00);
		rd(16'h0042, 8'h00);
		pin_chk(3'h1, 3'h1);
		done_test("reset");
		@(posedge sys_clk) pwr_pin <= 1'b1;
		for (i = 0; i < 4; i++)
		begin
			wr(`CPFS_ADDR_PRI, {i[1:0], 6'h3f});
			settle();
			cmp({6'h00, pdn, stby}, {6'h00, i == 0, i == 1}, "pwr");
			cmp({7'h00, cen}, {7'h00, i > 1}, "chan en");
			cmp({6'h00, ceff}, 8'h02, "chan eff");
		end
		wr(`CPFS_ADDR_PRI, 8'h3f);
		pwr_pin <= 1'b0;
		settle();
		cmp({6'h00, pdn, cen}, 8'h01, "pin low");
		done_test("power");
		@(posedge sys_clk) fd_a <= 1'b1;
		wr(`CPFS_ADDR_PRI, 8'h00);
		settle();
		pin_chk(3'h6, 3'h2);
		@(posedge sys_clk) fd_a <= 1'b0;
		fd_b <= 1'b1;
		settle();
		pin_chk(3'h2, 3'h6);
		wr(`CPFS_ADDR_PRI, 8'h09);
		@(posedge sys_clk) fd_b <= 1'b0;
		lmfc <= 1'b1;
		settle();
		pin_chk(3'h6, 3'h6);
		@(posedge sys_clk) lmfc <= 1'b0;
		settle();
		pin_chk(3'h2, 3'h2);
		for (k = 2; k < 6; k++)
		begin
			wr(`CPFS_ADDR_PRI, {2'h0, k[2:0], k[2:0]});
			settle();
			pin_chk(3'h1, 3'h1);
		end
		done_test("roles");
		wr(`CPFS_ADDR_SEC, 8'h88);
		settle();
		pin_chk(3'h1, 3'h1);
		@(posedge sys_clk) lead <= 1'b1;
		wr(`CPFS_ADDR_PRI, 8'h36);
		settle();
		pin_chk(3'h6, 3'h6);
		@(posedge sys_clk) lead <= 1'b0;
		settle();
		pin_chk(3'h2, 3'h2);
		wr(`CPFS_ADDR_SEC, 8'h55);
		settle();
		pin_chk(3'h1, 3'h1);
		wr(`CPFS_ADDR_SEC, 8'h00);
		drv_en <= 2'h3;
		drv_val <= 2'h1;
		settle();
		pin_chk(3'h0, 3'h0);
		cmp({6'h00, nsel}, 8'h01, "select");
		@(posedge sys_clk) drv_val <= 2'h2;
		settle();
		cmp({6'h00, nsel}, 8'h02, "select");
		done_test("secondary");
		@(posedge sys_clk) drv_val <= 2'h0;
		settle();
		cmp({6'h00, nsel}, 8'h00, "select low");
		wr(`CPFS_ADDR_SEC, 8'h11);
		settle();
		cmp({7'h00, xload}, 8'h00, "xfer idle");
		@(posedge sys_clk) drv_val <= 2'h1;
		settle();
		cmp({7'h00, xload}, 8'h01, "xfer pin");
		@(posedge sys_clk) xdone <= 1'b1;
		@(posedge sys_clk) xdone <= 1'b0;
		#1 cmp({7'h00, xload}, 8'h00, "xfer done");
		@(posedge sys_clk) drv_val <= 2'h0;
		settle();
		wr(`CPFS_ADDR_SEC, 8'h99);
		settle();
		@(posedge sys_clk) drv_val <= 2'h2;
		k = 0;
		repeat (8)
		begin
			@(posedge sys_clk);
			#1 k += (ftrig === 1'b1);
		end
		cmp(k[7:0], 8'h01, "trigger");
		@(posedge sys_clk) drv_en <= 2'h0;
		done_test("pin inputs");
		wr(`CPFS_ADDR_XFER, 8'h01);
		#1 cmp({7'h00, xload}, 8'h01, "xfer reg");
		rd(`CPFS_ADDR_XFER, 8'h01);
		@(posedge sys_clk) xdone <= 1'b1;
		@(posedge sys_clk) xdone <= 1'b0;
		rd(`CPFS_ADDR_XFER, 8'h00);
		done_test("transfer");
		complete_run();
	end
endmodule : cpfs_pin_select_tb
